// >>> core/cmc_pkg.sv
// Package: register map, field positions, reset values and modes of the comparator control block
package cmc_pkg;

   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned SYNC_STAGES = 2;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] CTRL_ADDR     = 8'h9B;
   localparam logic [7:0] MODE_ADDR     = 8'h9D;
   localparam logic [7:0] MUX_ADDR      = 8'h9F;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'hA0;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'hA1;
   localparam logic [7:0] AUX_ADDR      = 8'hA2;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] MODE_RST     = 8'h02;
   localparam logic [7:0] MUX_RST      = 8'h77;
   localparam logic [1:0] IRQ_STAT_RST = 2'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam logic       AUX_RST      = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned CTRL_ON_BIT    = 7;
   localparam int unsigned CTRL_STATE_BIT = 6;
   localparam int unsigned CTRL_RISE_BIT  = 5;
   localparam int unsigned CTRL_FALL_BIT  = 4;
   localparam int unsigned CTRL_HYP_LSB   = 2;
   localparam int unsigned CTRL_HYN_LSB   = 0;
   localparam int unsigned MUX_MINUS_LSB  = 4;
   localparam int unsigned MUX_PLUS_LSB   = 0;
   localparam int unsigned MODE_RIE_BIT   = 5;
   localparam int unsigned MODE_FIE_BIT   = 4;
   localparam int unsigned MODE_RT_LSB    = 0;
   localparam int unsigned STAT_RISE_BIT  = 0;
   localparam int unsigned STAT_FALL_BIT  = 1;
   localparam int unsigned AUX_RST_EN_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Modes
   typedef enum logic [1:0] {
      CMC_HYST_OFF  = 2'b00,
      CMC_HYST_5MV  = 2'b01,
      CMC_HYST_10MV = 2'b10,
      CMC_HYST_20MV = 2'b11
   } cmc_hyst_e;

   typedef enum logic [1:0] {
      CMC_RESP_FASTEST = 2'b00,
      CMC_RESP_MODE1   = 2'b01,
      CMC_RESP_MODE2   = 2'b10,
      CMC_RESP_LOWPWR  = 2'b11
   } cmc_resp_e;

endpackage

// >>> core/cmc_edge_if.sv
// Interface: synchronised comparator level and its edge pulses
`timescale 1ns/1ns
`default_nettype none
interface cmc_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// >>> core/cmc_sync_edge.sv
// Synchroniser and edge detector for the raw comparator result
`timescale 1ns/1ns
`default_nettype none
module cmc_sync_edge #(
   parameter int unsigned SYNC_STAGES = cmc_pkg::SYNC_STAGES
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Asynchronous comparator result
   input  wire logic raw_i,
   // Synchronised level and edges
   cmc_edge_if.src   edge_o
);

   if (SYNC_STAGES < 2) begin : g_chk
      $error("cmc_sync_edge needs at least two synchroniser stages");
   end

   logic [SYNC_STAGES-1:0] sync_q;
   logic [SYNC_STAGES-1:0] sync_d;
   logic                   prev_q;
   logic                   prev_d;

   // First stage is read only by the second
   always_comb begin
      sync_d = {sync_q[SYNC_STAGES-2:0], raw_i};
      prev_d = sync_q[SYNC_STAGES-1];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_q <= '0;
         prev_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Compare with the value one clock earlier
   assign edge_o.level = sync_q[SYNC_STAGES-1];
   assign edge_o.rise  = sync_q[SYNC_STAGES-1] & ~prev_q;
   assign edge_o.fall  = ~sync_q[SYNC_STAGES-1] & prev_q;

endmodule
`default_nettype wire

// >>> core/cmc_top.sv
// Comparator control and status logic with register port and interrupt
`timescale 1ns/1ns
`default_nettype none
module cmc_top #(
   parameter int unsigned SYNC_STAGES = cmc_pkg::SYNC_STAGES
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_we_i,
   input  wire logic       reg_re_i,
   output logic      [7:0] reg_rdata_o,
   // Analog comparator
   input  wire logic       cmp_raw_i,
   output logic            cmp_enable_o,
   output logic      [3:0] plus_input_sel_o,
   output logic      [3:0] minus_input_sel_o,
   output logic      [1:0] pos_hyst_sel_o,
   output logic      [1:0] neg_hyst_sel_o,
   output logic      [1:0] response_time_sel_o,
   // Port pin outputs
   output logic            latched_compare_out_o,
   output logic            raw_compare_out_o,
   // System
   output logic            osc_wake_o,
   output logic            reset_req_o,
   output logic            irq_o
);

   cmc_edge_if ei ();

   cmc_sync_edge #(
      .SYNC_STAGES (SYNC_STAGES)
   ) u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .raw_i  (cmp_raw_i),
      .edge_o (ei)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register state
   logic                on_q, on_d;
   logic                rise_flag_q, rise_flag_d;
   logic                fall_flag_q, fall_flag_d;
   cmc_pkg::cmc_hyst_e  hyp_q, hyp_d;
   cmc_pkg::cmc_hyst_e  hyn_q, hyn_d;
   logic [3:0]          plus_sel_q, plus_sel_d;
   logic [3:0]          minus_sel_q, minus_sel_d;
   logic                rie_q, rie_d;
   logic                fie_q, fie_d;
   cmc_pkg::cmc_resp_e  rt_q, rt_d;
   logic [1:0]          stat_q, stat_d;
   logic [1:0]          mask_q, mask_d;
   logic                rst_en_q, rst_en_d;
   logic [7:0]          rdata_q, rdata_d;
   logic                latched_q, latched_d;
   logic                reset_req_q, reset_req_d;
   logic                irq_q, irq_d;

   logic                wr_ctrl, wr_mode, wr_mux, wr_stat, wr_mask, wr_aux;
   logic                cmp_state;
   logic                rise_evt, fall_evt;
   logic [1:0]          irq_en;

   assign wr_ctrl = reg_we_i && (reg_addr_i == cmc_pkg::CTRL_ADDR);
   assign wr_mode = reg_we_i && (reg_addr_i == cmc_pkg::MODE_ADDR);
   assign wr_mux  = reg_we_i && (reg_addr_i == cmc_pkg::MUX_ADDR);
   assign wr_stat = reg_we_i && (reg_addr_i == cmc_pkg::IRQ_STAT_ADDR);
   assign wr_mask = reg_we_i && (reg_addr_i == cmc_pkg::IRQ_MASK_ADDR);
   assign wr_aux  = reg_we_i && (reg_addr_i == cmc_pkg::AUX_ADDR);

   // A disabled comparator counts as low, so no edges are seen while off
   assign cmp_state = on_q & ei.level;
   assign rise_evt  = on_q & ei.rise;
   assign fall_evt  = on_q & ei.fall;
   assign irq_en    = {fie_q, rie_q};

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      on_d        = on_q;
      hyp_d       = hyp_q;
      hyn_d       = hyn_q;
      rise_flag_d = rise_flag_q;
      fall_flag_d = fall_flag_q;
      if (wr_ctrl) begin
         on_d        = reg_wdata_i[cmc_pkg::CTRL_ON_BIT];
         hyp_d       = cmc_pkg::cmc_hyst_e'(reg_wdata_i[cmc_pkg::CTRL_HYP_LSB +: 2]);
         hyn_d       = cmc_pkg::cmc_hyst_e'(reg_wdata_i[cmc_pkg::CTRL_HYN_LSB +: 2]);
         rise_flag_d = reg_wdata_i[cmc_pkg::CTRL_RISE_BIT];
         fall_flag_d = reg_wdata_i[cmc_pkg::CTRL_FALL_BIT];
      end
      // Edges override a clear in the same cycle
      if (rise_evt) begin
         rise_flag_d = 1'b1;
      end
      if (fall_evt) begin
         fall_flag_d = 1'b1;
      end

      plus_sel_d  = plus_sel_q;
      minus_sel_d = minus_sel_q;
      if (wr_mux) begin
         minus_sel_d = reg_wdata_i[cmc_pkg::MUX_MINUS_LSB +: 4];
         plus_sel_d  = reg_wdata_i[cmc_pkg::MUX_PLUS_LSB +: 4];
      end

      rie_d = rie_q;
      fie_d = fie_q;
      rt_d  = rt_q;
      if (wr_mode) begin
         rie_d = reg_wdata_i[cmc_pkg::MODE_RIE_BIT];
         fie_d = reg_wdata_i[cmc_pkg::MODE_FIE_BIT];
         rt_d  = cmc_pkg::cmc_resp_e'(reg_wdata_i[cmc_pkg::MODE_RT_LSB +: 2]);
      end

      // Write one to clear; a new event in the same cycle keeps the bit
      stat_d = stat_q;
      if (wr_stat) begin
         stat_d = stat_q & ~reg_wdata_i[1:0];
      end
      stat_d[cmc_pkg::STAT_RISE_BIT] = stat_d[cmc_pkg::STAT_RISE_BIT] | rise_evt;
      stat_d[cmc_pkg::STAT_FALL_BIT] = stat_d[cmc_pkg::STAT_FALL_BIT] | fall_evt;

      mask_d = wr_mask ? reg_wdata_i[1:0] : mask_q;
      rst_en_d = wr_aux ? reg_wdata_i[cmc_pkg::AUX_RST_EN_BIT] : rst_en_q;

      // Unmapped or idle reads return zero
      rdata_d = 8'h00;
      if (reg_re_i) begin
         unique case (reg_addr_i)
            cmc_pkg::CTRL_ADDR:     rdata_d = {on_q, cmp_state, rise_flag_q, fall_flag_q,
                                               hyp_q, hyn_q};
            cmc_pkg::MODE_ADDR:     rdata_d = {2'h0, rie_q, fie_q, 2'h0, rt_q};
            cmc_pkg::MUX_ADDR:      rdata_d = {minus_sel_q, plus_sel_q};
            cmc_pkg::IRQ_STAT_ADDR: rdata_d = {6'h00, stat_q};
            cmc_pkg::IRQ_MASK_ADDR: rdata_d = {6'h00, mask_q};
            cmc_pkg::AUX_ADDR:      rdata_d = {7'h00, rst_en_q};
            default:                rdata_d = 8'h00;
         endcase
      end

      latched_d   = cmp_state;
      reset_req_d = on_q & rst_en_q & ~ei.level;
      irq_d       = |(stat_q & mask_q & irq_en);
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         on_q        <= cmc_pkg::CTRL_RST[cmc_pkg::CTRL_ON_BIT];
         rise_flag_q <= cmc_pkg::CTRL_RST[cmc_pkg::CTRL_RISE_BIT];
         fall_flag_q <= cmc_pkg::CTRL_RST[cmc_pkg::CTRL_FALL_BIT];
         hyp_q       <= cmc_pkg::cmc_hyst_e'(cmc_pkg::CTRL_RST[cmc_pkg::CTRL_HYP_LSB +: 2]);
         hyn_q       <= cmc_pkg::cmc_hyst_e'(cmc_pkg::CTRL_RST[cmc_pkg::CTRL_HYN_LSB +: 2]);
         plus_sel_q  <= cmc_pkg::MUX_RST[cmc_pkg::MUX_PLUS_LSB +: 4];
         minus_sel_q <= cmc_pkg::MUX_RST[cmc_pkg::MUX_MINUS_LSB +: 4];
         rie_q       <= cmc_pkg::MODE_RST[cmc_pkg::MODE_RIE_BIT];
         fie_q       <= cmc_pkg::MODE_RST[cmc_pkg::MODE_FIE_BIT];
         rt_q        <= cmc_pkg::cmc_resp_e'(cmc_pkg::MODE_RST[cmc_pkg::MODE_RT_LSB +: 2]);
         stat_q      <= cmc_pkg::IRQ_STAT_RST;
         mask_q      <= cmc_pkg::IRQ_MASK_RST;
         rst_en_q    <= cmc_pkg::AUX_RST;
         rdata_q     <= 8'h00;
         latched_q   <= 1'b0;
         reset_req_q <= 1'b0;
         irq_q       <= 1'b0;
      end else begin
         on_q        <= on_d;
         rise_flag_q <= rise_flag_d;
         fall_flag_q <= fall_flag_d;
         hyp_q       <= hyp_d;
         hyn_q       <= hyn_d;
         plus_sel_q  <= plus_sel_d;
         minus_sel_q <= minus_sel_d;
         rie_q       <= rie_d;
         fie_q       <= fie_d;
         rt_q        <= rt_d;
         stat_q      <= stat_d;
         mask_q      <= mask_d;
         rst_en_q    <= rst_en_d;
         rdata_q     <= rdata_d;
         latched_q   <= latched_d;
         reset_req_q <= reset_req_d;
         irq_q       <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata_o           = rdata_q;
   assign cmp_enable_o          = on_q;
   assign plus_input_sel_o      = plus_sel_q;
   assign minus_input_sel_o     = minus_sel_q;
   assign pos_hyst_sel_o        = hyp_q;
   assign neg_hyst_sel_o        = neg_hyst_cast(hyn_q);
   assign response_time_sel_o   = rt_q;
   assign latched_compare_out_o = latched_q;
   // Raw path bypasses the synchroniser, gated only by the on_q flop, so it still works with the clock stopped
   assign raw_compare_out_o     = cmp_raw_i & on_q;
   // Wake must act in suspend, hence also taken from the raw result
   assign osc_wake_o            = on_q & ~cmp_raw_i;
   assign reset_req_o           = reset_req_q;
   assign irq_o                 = irq_q;

   function automatic logic [1:0] neg_hyst_cast(input cmc_pkg::cmc_hyst_e h);
      neg_hyst_cast = h;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Enable must still stand when the synchronised level is latched
   sequence s_raw_high3;
      (on_q && cmp_raw_i) [*3] ##1 on_q;
   endsequence

   sequence s_ctrl_read;
      reg_re_i && (reg_addr_i == cmc_pkg::CTRL_ADDR);
   endsequence

   AST_OFF_LATCH_LOW: assert property (!on_q |=> !latched_compare_out_o)
      else $error("latched output high while comparator disabled");

   AST_RAW_PATH: assert property (raw_compare_out_o == (cmp_raw_i && cmp_enable_o))
      else $error("raw output does not follow comparator");

   AST_SYNC_DELAY: assert property (s_raw_high3 |-> ei.level ##1 latched_compare_out_o)
      else $error("synchronised level late or latched output missing");

   AST_RISE_SET: assert property (rise_evt |=> rise_flag_q)
      else $error("rising edge did not set flag");

   AST_FALL_SET: assert property (fall_evt |=> fall_flag_q)
      else $error("falling edge did not set flag");

   AST_FLAG_STICKY: assert property (rise_flag_q && !wr_ctrl |=> rise_flag_q)
      else $error("rising flag cleared without software write");

   AST_STATE_READ: assert property (s_ctrl_read |=>
         reg_rdata_o[cmc_pkg::CTRL_STATE_BIT] == $past(cmp_state))
      else $error("state bit read wrong");

   AST_ENABLE_WR: assert property (wr_ctrl |=>
         cmp_enable_o == $past(reg_wdata_i[7]))
      else $error("enable bit write not applied");

   AST_WAKE: assert property (osc_wake_o == (cmp_enable_o && !cmp_raw_i))
      else $error("wake request mismatch");

   AST_IRQ: assert property ((|(stat_q & mask_q & irq_en)) |=> irq_o)
      else $error("enabled pending event did not raise interrupt");

   AST_MUX_WR: assert property (wr_mux |=>
         {minus_input_sel_o, plus_input_sel_o} == $past(reg_wdata_i))
      else $error("input select write not applied");

   AST_RESET_REQ: assert property (on_q && rst_en_q && !ei.level |=> reset_req_o)
      else $error("reset request missing");

endmodule
`default_nettype wire

// >>> testbench/cmc_cmp_model.sv
// Behavioural analog comparator with input pins, selects and response delay
`timescale 1ns/1ns
`default_nettype none
module cmc_cmp_model (
   // Control from the block
   input  wire logic        enable_i,
   input  wire logic [3:0]  plus_sel_i,
   input  wire logic [3:0]  minus_sel_i,
   input  wire logic [1:0]  rt_i,
   // Pin voltages in millivolts
   input  wire logic [15:0] pin_mv_i [16],
   // Raw result
   output var  logic        raw_o
);
   logic cmp_now;

   initial raw_o = 1'b0;
   // Separate selects, one pin each; powered off reads low
   assign cmp_now = enable_i && (pin_mv_i[plus_sel_i] > pin_mv_i[minus_sel_i]);
   // Slower response modes settle later
   always @(cmp_now) raw_o <= #(1 + 2 * rt_i) cmp_now;
endmodule
`default_nettype wire

// >>> testbench/cmc_top_test.sv
// Self-checking testbench of the comparator control block
`timescale 1ns/1ns
`default_nettype none
module cmc_top_test;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        clk_run = 1'b1;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_we_i = 1'b0;
   logic        reg_re_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic        cmp_raw_i;
   logic        cmp_enable_o;
   logic [3:0]  plus_input_sel_o;
   logic [3:0]  minus_input_sel_o;
   logic [1:0]  pos_hyst_sel_o;
   logic [1:0]  neg_hyst_sel_o;
   logic [1:0]  response_time_sel_o;
   logic        latched_compare_out_o;
   logic        raw_compare_out_o;
   logic        osc_wake_o;
   logic        reset_req_o;
   logic        irq_o;
   logic [15:0] pin_mv [16];
   int          fails = 0;
   int          checks = 0;

   // Clock can be halted to mimic stop and suspend modes
   always #5 if (clk_run) clk_i = ~clk_i;

   cmc_top cmc_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .cmp_raw_i(cmp_raw_i), .cmp_enable_o(cmp_enable_o),
      .plus_input_sel_o(plus_input_sel_o), .minus_input_sel_o(minus_input_sel_o),
      .pos_hyst_sel_o(pos_hyst_sel_o), .neg_hyst_sel_o(neg_hyst_sel_o),
      .response_time_sel_o(response_time_sel_o),
      .latched_compare_out_o(latched_compare_out_o), .raw_compare_out_o(raw_compare_out_o),
      .osc_wake_o(osc_wake_o), .reset_req_o(reset_req_o), .irq_o(irq_o)
   );

   cmc_cmp_model cmc_cmp_model_inst (
      .enable_i(cmp_enable_o), .plus_sel_i(plus_input_sel_o),
      .minus_sel_i(minus_input_sel_o), .rt_i(response_time_sel_o),
      .pin_mv_i(pin_mv), .raw_o(cmp_raw_i)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_we_i    <= 1'b1;
      @(posedge clk_i);
      reg_we_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i   <= 1'b1;
      @(posedge clk_i);
      reg_re_i   <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(name, d, exp);
   endtask

   task automatic set_pin(input int p, input logic [15:0] mv);
      @(posedge clk_i);
      pin_mv[p] <= mv;
      repeat (6) @(posedge clk_i);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      rdchk("ctrl", cmc_pkg::CTRL_ADDR, 8'h00);
      rdchk("mode", cmc_pkg::MODE_ADDR, 8'h02);
      rdchk("mux", cmc_pkg::MUX_ADDR, 8'h77);
      rdchk("stat", cmc_pkg::IRQ_STAT_ADDR, 8'h00);
      rdchk("mask", cmc_pkg::IRQ_MASK_ADDR, 8'h00);
      rdchk("aux", cmc_pkg::AUX_ADDR, 8'h00);
      rdchk("unmapped", 8'h9C, 8'h00);
      @(posedge clk_i);
      #1 chk("rdata idle", reg_rdata_o, 8'h00);
      chk("raw out", {7'h0, raw_compare_out_o}, 8'h00);
      chk("wake", {7'h0, osc_wake_o}, 8'h00);
   endtask

   task automatic t_regs;
      wr(cmc_pkg::MUX_ADDR, 8'h5A);
      #1 chk("plus sel", {4'h0, plus_input_sel_o}, 8'h0A);
      chk("minus sel", {4'h0, minus_input_sel_o}, 8'h05);
      for (int i = 0; i < 4; i++) begin
         wr(cmc_pkg::CTRL_ADDR, {4'h0, 2'(i), 2'(3 - i)});
         wr(cmc_pkg::MODE_ADDR, {6'h00, 2'(i)});
         #1 chk("hyp", {6'h0, pos_hyst_sel_o}, 8'(i));
         chk("hyn", {6'h0, neg_hyst_sel_o}, 8'(3 - i));
         chk("resp", {6'h0, response_time_sel_o}, 8'(i));
         rdchk("ctrl hyst", cmc_pkg::CTRL_ADDR, {4'h0, 2'(i), 2'(3 - i)});
      end
      wr(cmc_pkg::MODE_ADDR, 8'hFF);
      rdchk("mode ro", cmc_pkg::MODE_ADDR, 8'h33);
      wr(cmc_pkg::CTRL_ADDR, 8'h40);
      rdchk("state ro", cmc_pkg::CTRL_ADDR, 8'h00);
   endtask

   task automatic t_edges;
      wr(cmc_pkg::MUX_ADDR, 8'h21);
      wr(cmc_pkg::MODE_ADDR, 8'h30);
      wr(cmc_pkg::IRQ_MASK_ADDR, 8'h03);
      wr(cmc_pkg::CTRL_ADDR, 8'h80);
      // Clear flags once the comparator has powered up
      wr(cmc_pkg::CTRL_ADDR, 8'h80);
      wr(cmc_pkg::IRQ_STAT_ADDR, 8'h03);
      #1 chk("wake low out", {7'h0, osc_wake_o}, 8'h01);
      @(posedge clk_i);
      pin_mv[1] <= 16'd300;
      @(posedge clk_i);
      #1 chk("sync delay", {7'h0, latched_compare_out_o}, 8'h00);
      repeat (5) @(posedge clk_i);
      #1 chk("latched hi", {7'h0, latched_compare_out_o}, 8'h01);
      chk("raw hi", {7'h0, raw_compare_out_o}, 8'h01);
      chk("wake hi out", {7'h0, osc_wake_o}, 8'h00);
      chk("irq rise", {7'h0, irq_o}, 8'h01);
      rdchk("ctrl rise", cmc_pkg::CTRL_ADDR, 8'hE0);
      set_pin(1, 16'd100);
      rdchk("ctrl fall", cmc_pkg::CTRL_ADDR, 8'hB0);
      rdchk("stat both", cmc_pkg::IRQ_STAT_ADDR, 8'h03);
      wr(cmc_pkg::IRQ_STAT_ADDR, 8'h01);
      rdchk("stat w1c", cmc_pkg::IRQ_STAT_ADDR, 8'h02);
      chk("irq fall", {7'h0, irq_o}, 8'h01);
      wr(cmc_pkg::IRQ_MASK_ADDR, 8'h01);
      repeat (2) @(posedge clk_i);
      #1 chk("irq masked", {7'h0, irq_o}, 8'h00);
      wr(cmc_pkg::CTRL_ADDR, 8'h80);
      rdchk("flags clr", cmc_pkg::CTRL_ADDR, 8'h80);
      // Falling enable off: falling edges alone must not interrupt
      wr(cmc_pkg::IRQ_STAT_ADDR, 8'h03);
      wr(cmc_pkg::IRQ_MASK_ADDR, 8'h03);
      wr(cmc_pkg::MODE_ADDR, 8'h20);
      set_pin(1, 16'd300);
      set_pin(1, 16'd100);
      wr(cmc_pkg::IRQ_STAT_ADDR, 8'h01);
      repeat (2) @(posedge clk_i);
      #1 chk("irq rise only", {7'h0, irq_o}, 8'h00);
   endtask

   task automatic t_reset_src;
      wr(cmc_pkg::AUX_ADDR, 8'h01);
      repeat (4) @(posedge clk_i);
      #1 chk("rst req low", {7'h0, reset_req_o}, 8'h01);
      set_pin(1, 16'd300);
      chk("rst req hi", {7'h0, reset_req_o}, 8'h00);
      wr(cmc_pkg::AUX_ADDR, 8'h00);
   endtask

   task automatic t_async;
      set_pin(1, 16'd100);
      @(posedge clk_i);
      #2 clk_run = 1'b0;
      pin_mv[1] = 16'd300;
      #30 chk("raw noclk hi", {7'h0, raw_compare_out_o}, 8'h01);
      chk("latched noclk", {7'h0, latched_compare_out_o}, 8'h00);
      pin_mv[1] = 16'd100;
      #30 chk("raw noclk lo", {7'h0, raw_compare_out_o}, 8'h00);
      chk("wake noclk", {7'h0, osc_wake_o}, 8'h01);
      clk_run = 1'b1;
   endtask

   task automatic t_disable;
      set_pin(1, 16'd300);
      wr(cmc_pkg::CTRL_ADDR, 8'h00);
      repeat (4) @(posedge clk_i);
      #1 chk("en off", {7'h0, cmp_enable_o}, 8'h00);
      chk("raw off", {7'h0, raw_compare_out_o}, 8'h00);
      chk("latched off", {7'h0, latched_compare_out_o}, 8'h00);
      chk("wake off", {7'h0, osc_wake_o}, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Verdict
   task automatic summarize;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      // Whole sequence needs well under 2000 cycles
      #200000;
      fails++;
      summarize();
   end

   initial begin
      for (int p = 0; p < 16; p++) pin_mv[p] = 16'd0;
      pin_mv[2] = 16'd200;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_regs();
      t_edges();
      t_reset_src();
      t_async();
      t_disable();
      summarize();
   end
endmodule
`default_nettype wire
